// ---- verilog/dmt_pkg.sv ----
// Constants and carriers for the dual mode timer status and CPU port block.
// Assumes an 8-bit peripheral bus with one select code per byte register.
package dmt_pkg;
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 3;

  // Register select codes on the byte bus
  localparam logic [AW-1:0] A_CTRL    = 3'h0;
  localparam logic [AW-1:0] A_STATUS  = 3'h1;
  localparam logic [AW-1:0] A_CNT_HI  = 3'h2;
  localparam logic [AW-1:0] A_CNT_LO  = 3'h3;
  localparam logic [AW-1:0] A_CMP_HI  = 3'h4;
  localparam logic [AW-1:0] A_CMP_LO  = 3'h5;
  localparam logic [AW-1:0] A_CLKSTOP = 3'h6;

  // Status register field positions
  localparam int unsigned B_OVF_H  = 7;
  localparam int unsigned B_CMF_H  = 6;
  localparam int unsigned B_OVIE_H = 5;
  localparam int unsigned B_CCLR_H = 4;
  localparam int unsigned B_OVF_L  = 3;
  localparam int unsigned B_CMF_L  = 2;
  localparam int unsigned B_OVIE_L = 1;
  localparam int unsigned B_CCLR_L = 0;
  localparam logic [DW-1:0] FLAG_MASK = 8'hcc;

  // Control register split select and clock stop standby bit
  localparam int unsigned B_SPLIT   = 6;
  localparam int unsigned B_STANDBY = 2;

  // Reset values
  localparam logic [DW-1:0]   RST_CTRL    = 8'h00;
  localparam logic [DW-1:0]   RST_STATUS  = 8'h00;
  localparam logic [DW-1:0]   RST_CLKSTOP = 8'hff;
  localparam logic [2*DW-1:0] RST_CNT     = 16'h0000;
  localparam logic [2*DW-1:0] RST_CMP     = 16'hffff;
  localparam logic [DW-1:0]   BYTE_MAX    = 8'hff;
  localparam logic [DW-1:0]   BYTE_ZERO   = 8'h00;

  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dmt_cpu_req_t;

  typedef struct packed {
    logic irq_h;
    logic irq_l;
  } dmt_irq_t;
endpackage : dmt_pkg

// ---- verilog/dmt_status_cpu_port.sv ----
// Control/status flags, standby control and byte-wide CPU port of a 16-bit
// up-counter that can split into two 8-bit counters.
// Assumes count ticks arrive as one-cycle enables from an outside prescaler
// and that the CPU issues at most one byte access per cycle.
// The small flag cell at the end of this file serves the four event flags.
`timescale 1ns/1ps

module dmt_status_cpu_port (
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_nrst,
  // CPU byte port
  input  wire dmt_pkg::dmt_cpu_req_t i_cpu,
  output logic [dmt_pkg::DW-1:0]     o_rdata,
  // Count enables from the prescaler
  input  wire logic                  i_tick_l,
  input  wire logic                  i_tick_h,
  // Interrupt request pulses and standby state
  output dmt_pkg::dmt_irq_t          o_irq,
  output logic                       o_standby
);
  import dmt_pkg::*;

  logic [DW-1:0]   ctrl_q, ctrl_d;
  logic [DW-1:0]   status_q, status_d;
  logic [DW-1:0]   clkstop_q, clkstop_d;
  // Flags live in their own cells; status_q keeps the enables and clear selects
  logic [DW-1:0]   status_view;
  wire  [DW-1:0]   flag_vec;
  logic [2*DW-1:0] cnt_q, cnt_d;
  logic [2*DW-1:0] cmp_q, cmp_d;
  logic [DW-1:0]   temp_q, temp_d;
  logic [DW-1:0]   rdata_q, rdata_d;
  dmt_irq_t        irq_q, irq_d;
  logic            standby_q, standby_d;

  logic split, running, tick_lo, tick_hi;
  logic match16, match_lo, match_hi;
  logic ovf_h_ev, ovf_l_ev, cmf_h_ev, cmf_l_ev;
  logic wr_status, rd_status;
  logic [DW-1:0] set_vec;

  assign split   = ctrl_q[B_SPLIT];
  assign running = clkstop_q[B_STANDBY];
  assign tick_lo = i_tick_l & running;
  // In 16-bit mode the high byte is carried only through the full count
  assign tick_hi = i_tick_h & running & split;

  assign match16  = (cnt_q == cmp_q);
  assign match_lo = (cnt_q[DW-1:0] == cmp_q[DW-1:0]);
  assign match_hi = (cnt_q[2*DW-1:DW] == cmp_q[2*DW-1:DW]);

  assign wr_status = i_cpu.wr & (i_cpu.addr == A_STATUS);
  assign rd_status = i_cpu.rd & (i_cpu.addr == A_STATUS);

  // Counter, compare, holding register and read data
  always_comb begin
    cnt_d    = cnt_q;
    cmp_d    = cmp_q;
    temp_d   = temp_q;
    rdata_d  = BYTE_ZERO;
    ovf_h_ev = 1'b0;
    ovf_l_ev = 1'b0;
    cmf_h_ev = 1'b0;
    cmf_l_ev = 1'b0;
    // Match is signalled as the counter leaves the matching value
    if (!split) begin
      if (tick_lo) begin
        // Full match sets high compare flag
        cmf_h_ev = match16;
        // Low bits match sets low flag
        cmf_l_ev = match_lo;
        // Low bits wrap in 16-bit mode
        ovf_l_ev = (cnt_q[DW-1:0] == BYTE_MAX);
        if (match16 && status_q[B_CCLR_H]) begin
          cnt_d = RST_CNT;
        end else begin
          ovf_h_ev = (cnt_q == {BYTE_MAX, BYTE_MAX});
          cnt_d    = cnt_q + 16'h0001;
        end
      end
    end else begin
      if (tick_lo) begin
        cmf_l_ev = match_lo;
        if (match_lo && status_q[B_CCLR_L]) begin
          cnt_d[DW-1:0] = BYTE_ZERO;
        end else begin
          ovf_l_ev      = (cnt_q[DW-1:0] == BYTE_MAX);
          cnt_d[DW-1:0] = cnt_q[DW-1:0] + 8'h01;
        end
      end
      if (tick_hi) begin
        cmf_h_ev = match_hi;
        if (match_hi && status_q[B_CCLR_H]) begin
          cnt_d[2*DW-1:DW] = BYTE_ZERO;
        end else begin
          ovf_h_ev         = (cnt_q[2*DW-1:DW] == BYTE_MAX);
          cnt_d[2*DW-1:DW] = cnt_q[2*DW-1:DW] + 8'h01;
        end
      end
    end
    // CPU writes take precedence over a count in the same cycle
    if (i_cpu.wr) begin
      case (i_cpu.addr)
        A_CNT_HI: begin
          // Upper write goes only to holding in 16-bit mode
          if (!split) begin
            temp_d = i_cpu.wdata;
          end else begin
            // Direct byte write in split mode
            cnt_d[2*DW-1:DW] = i_cpu.wdata;
          end
          ovf_h_ev = 1'b0;
        end
        A_CNT_LO: begin
          if (!split) begin
            cnt_d = {temp_q, i_cpu.wdata};
          end else begin
            cnt_d[DW-1:0] = i_cpu.wdata;
          end
          ovf_l_ev = 1'b0;
          if (!split) begin
            ovf_h_ev = 1'b0;
          end
        end
        A_CMP_HI: begin
          if (!split) begin
            temp_d = i_cpu.wdata;
          end else begin
            cmp_d[2*DW-1:DW] = i_cpu.wdata;
          end
        end
        A_CMP_LO: begin
          if (!split) begin
            cmp_d = {temp_q, i_cpu.wdata};
          end else begin
            cmp_d[DW-1:0] = i_cpu.wdata;
          end
        end
        default: begin
        end
      endcase
    end
    if (i_cpu.rd) begin
      case (i_cpu.addr)
        A_STATUS:  rdata_d = status_view;
        A_CLKSTOP: rdata_d = clkstop_q;
        A_CNT_HI: begin
          rdata_d = cnt_q[2*DW-1:DW];
          // Upper read latches live low byte
          if (!split) begin
            temp_d = cnt_q[DW-1:0];
          end
        end
        A_CNT_LO: begin
          rdata_d = split ? cnt_q[DW-1:0] : temp_q;
        end
        A_CMP_HI: rdata_d = cmp_q[2*DW-1:DW];
        A_CMP_LO: rdata_d = cmp_q[DW-1:0];
        // Control register is write-only and reads as zero
        default:  rdata_d = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q   <= RST_CNT;
      cmp_q   <= RST_CMP;
      temp_q  <= BYTE_ZERO;
      rdata_q <= BYTE_ZERO;
    end else begin
      cnt_q   <= cnt_d;
      cmp_q   <= cmp_d;
      temp_q  <= temp_d;
      rdata_q <= rdata_d;
    end
  end

  // Control, status, clock stop and request pulses
  always_comb begin
    ctrl_d    = ctrl_q;
    clkstop_d = clkstop_q;
    status_d  = status_q;
    set_vec   = BYTE_ZERO;
    set_vec[B_OVF_H] = ovf_h_ev;
    set_vec[B_CMF_H] = cmf_h_ev;
    set_vec[B_OVF_L] = ovf_l_ev;
    set_vec[B_CMF_L] = cmf_l_ev;
    if (i_cpu.wr && (i_cpu.addr == A_CTRL)) begin
      ctrl_d = i_cpu.wdata;
    end
    if (i_cpu.wr && (i_cpu.addr == A_CLKSTOP)) begin
      clkstop_d = i_cpu.wdata;
    end
    // Plain read/write bits only; flag positions stay zero here
    if (wr_status) begin
      status_d = i_cpu.wdata & ~FLAG_MASK;
    end
    irq_d.irq_h = (ovf_h_ev & status_q[B_OVIE_H]) | cmf_h_ev;
    irq_d.irq_l = (ovf_l_ev & status_q[B_OVIE_L]) | cmf_l_ev;
    standby_d   = ~clkstop_d[B_STANDBY];
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q    <= RST_CTRL;
      status_q  <= RST_STATUS;
      clkstop_q <= RST_CLKSTOP;
      irq_q     <= '0;
      standby_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      status_q  <= status_d;
      clkstop_q <= clkstop_d;
      irq_q     <= irq_d;
      standby_q <= standby_d;
    end
  end

  // One cell per event flag; the other positions read as plain bits
  for (genvar gi = 0; gi < DW; gi++) begin : g_flag
    if (FLAG_MASK[gi]) begin : g_cell
      dmt_flag_cell #(
        .RST_VAL (1'b0)
      ) u_cell (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_set     (set_vec[gi]),
        .i_read    (rd_status),
        .i_write   (wr_status),
        .i_wbit    (i_cpu.wdata[gi]),
        .o_flag    (flag_vec[gi])
      );
    end else begin : g_plain
      assign flag_vec[gi] = 1'b0;
    end
  end

  assign status_view = (status_q & ~FLAG_MASK) | (flag_vec & FLAG_MASK);

  assign o_rdata   = rdata_q;
  assign o_irq     = irq_q;
  assign o_standby = standby_q;
endmodule : dmt_status_cpu_port

// One software-cleared event flag: set by hardware, cleared by a written
// zero only after the flag has been read as one.
// Limitation: a read and a zero write in the same cycle do not clear;
// the clearing write has to follow the read.
module dmt_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  // Hardware set and CPU access to this bit
  input  wire logic i_set,
  input  wire logic i_read,
  input  wire logic i_write,
  input  wire logic i_wbit,
  // Current flag value
  output logic      o_flag
);
  logic flag_q, flag_d;
  logic armed_q, armed_d;

  always_comb begin
    flag_d  = flag_q;
    armed_d = armed_q;
    // Reading a one arms its clear
    if (i_read) begin
      armed_d = armed_q | flag_q;
    end
    if (i_write) begin
      if (!i_wbit && armed_q) begin
        flag_d = 1'b0;
      end
      // Written one never sets the flag
      armed_d = armed_q & i_wbit;
    end
    // Hardware set beats clear
    // Losing an event would be worse than a second read
    flag_d = flag_d | i_set;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_q  <= RST_VAL;
      armed_q <= 1'b0;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

  assign o_flag = flag_q;
endmodule : dmt_flag_cell

// ---- bench/dmt_status_checker.sv ----
// Port checker for the timer status and CPU port block.
// Assumes it is bound to the design top.
`timescale 1ns/1ps
module dmt_status_checker
  import dmt_pkg::*;
(
  // Watched ports
  input wire logic          i_sys_clk,
  input wire logic          i_nrst,
  input wire dmt_cpu_req_t  i_cpu,
  input wire logic [DW-1:0] o_rdata,
  input wire logic          i_tick_l,
  input wire logic          i_tick_h,
  input wire dmt_irq_t      o_irq,
  input wire logic          o_standby
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  wire rd_on = i_cpu.rd && !i_cpu.wr;
  sequence s_cs_wr;
    i_cpu.wr && i_cpu.addr == A_CLKSTOP;
  endsequence
  sequence s_cs_rd;
    rd_on && i_cpu.addr == A_CLKSTOP;
  endsequence
  a_rdata_idle_zero: assert property (!i_cpu.rd |=> o_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_unmapped_read_zero: assert property (rd_on && i_cpu.addr == 3'h7 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_read_zero: assert property (rd_on && i_cpu.addr == A_CTRL |=> o_rdata == 8'h00)
    else $error("control read not zero");
  a_stop_sets_standby: assert property (s_cs_wr and !i_cpu.wdata[2] |-> ##[1:2] o_standby)
    else $error("standby not entered");
  a_stop_read_back: assert property (s_cs_wr ##1 !i_cpu.wr ##1 s_cs_rd
    |=> o_rdata == $past(i_cpu.wdata, 3)) else $error("clock stop readback");
  a_irq_low_cause: assert property (o_irq.irq_l |-> $past(i_tick_l))
    else $error("low request without tick");
  a_irq_high_cause: assert property (o_irq.irq_h |-> $past(i_tick_l || i_tick_h))
    else $error("high request without tick");
  a_reset_quiet: assert property (disable iff (1'b0) !i_nrst
    |-> o_rdata == 8'h00 && o_irq == 2'b00 && !o_standby) else $error("outputs live in reset");
endmodule : dmt_status_checker

bind dmt_status_cpu_port dmt_status_checker u_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .i_cpu(i_cpu), .o_rdata(o_rdata), .i_tick_l(i_tick_l), .i_tick_h(i_tick_h),
  .o_irq(o_irq), .o_standby(o_standby));

// ---- bench/dmt_cpu_model.sv ----
// CPU side of the byte port, one access per wr or rd call; wr16 makes two.
// Assumes clk is the system clock; tasks start at a rising edge.
`timescale 1ns/1ps
module dmt_cpu_model
  import dmt_pkg::*;
(
  // Byte bus
  input  wire logic          clk,
  input  wire logic [DW-1:0] rdata,
  output dmt_cpu_req_t       req
);
  initial req = '0;
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    req <= '{1'b0, 1'b1, a, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  // Data sampled in the cycle after the strobe edge
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd
  task automatic wr16(input logic [AW-1:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(AW'(a + 1), d[7:0]);
  endtask : wr16
endmodule : dmt_cpu_model

// ---- bench/dmt_status_cpu_port_bench.sv ----
// Self-checking bench for the timer status and CPU port block.
// Assumes the fixed one-cycle read latency of the byte port.
`timescale 1ns/1ps
module dmt_status_cpu_port_bench;
  import dmt_pkg::*;
  logic          i_sys_clk = 1'b0;
  logic          i_nrst    = 1'b1;
  logic          i_tick_l  = 1'b0;
  logic          i_tick_h  = 1'b0;
  dmt_cpu_req_t  i_cpu;
  logic [DW-1:0] o_rdata;
  dmt_irq_t      o_irq;
  dmt_irq_t      irq_seen;
  logic          o_standby;
  int            n_mismatch = 0;
  int            num_checks = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  dmt_status_cpu_port dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cpu(i_cpu),
    .o_rdata(o_rdata), .i_tick_l(i_tick_l), .i_tick_h(i_tick_h), .o_irq(o_irq),
    .o_standby(o_standby));
  dmt_cpu_model cpu (.clk(i_sys_clk), .rdata(o_rdata), .req(i_cpu));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [AW-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    chk(d, e);
  endtask : rc
  // Request pulse lands one cycle after the tick edge
  task automatic tk(input logic h);
    if (h) i_tick_h <= 1'b1;
    else i_tick_l <= 1'b1;
    @(posedge i_sys_clk);
    i_tick_l <= 1'b0;
    i_tick_h <= 1'b0;
    #1 irq_seen = o_irq;
    @(posedge i_sys_clk);
  endtask : tk
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    i_nrst <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(posedge i_sys_clk);
    rc(A_STATUS, 8'h00);
    rc(A_CLKSTOP, 8'hff);
    rc(A_CMP_LO, 8'hff); rc(A_CTRL, 8'h00); rc(3'h7, 8'h00);
    $display("reset test done");
    cpu.wr(A_STATUS, 8'hff);
    rc(A_STATUS, 8'h33);
    cpu.wr(A_STATUS, 8'h22);
    cpu.wr16(A_CMP_HI, 16'h1234);
    cpu.wr16(A_CNT_HI, 16'hffff);
    tk(1'b0);
    chk({6'h00, irq_seen}, 8'h03);
    rc(A_STATUS, 8'haa);
    cpu.wr(A_STATUS, 8'h00);
    rc(A_STATUS, 8'h00);
    cpu.wr16(A_CNT_HI, 16'hffff);
    tk(1'b0);
    chk({6'h00, irq_seen}, 8'h00);
    cpu.wr(A_STATUS, 8'h00);
    rc(A_STATUS, 8'h88);
    cpu.wr(A_STATUS, 8'h00);
    rc(A_STATUS, 8'h00);
    $display("flag test done");
    cpu.wr16(A_CNT_HI, 16'h00ff);
    rc(A_CNT_HI, 8'h00);
    tk(1'b0);
    rc(A_CNT_LO, 8'hff);
    rc(A_CNT_HI, 8'h01);
    cpu.wr16(A_CNT_HI, 16'haa55);
    rc(A_CNT_HI, 8'haa); rc(A_CNT_LO, 8'h55);
    rc(A_CMP_LO, 8'h34); rc(A_CMP_HI, 8'h12);
    cpu.wr(A_STATUS, 8'h10);
    cpu.wr16(A_CNT_HI, 16'h1234);
    tk(1'b0);
    chk({6'h00, irq_seen}, 8'h03);
    rc(A_CNT_HI, 8'h00); rc(A_CNT_LO, 8'h00);
    rc(A_STATUS, 8'h5c);
    $display("wide test done");
    cpu.wr(A_CTRL, 8'h40);
    cpu.wr(A_STATUS, 8'h01);
    cpu.wr(A_CNT_LO, 8'h34);
    rc(A_CNT_LO, 8'h34);
    tk(1'b0);
    rc(A_CNT_LO, 8'h00);
    rc(A_STATUS, 8'h05);
    tk(1'b1);
    rc(A_CNT_HI, 8'h01);
    cpu.wr(A_CNT_HI, 8'hff);
    tk(1'b1);
    chk({6'h00, irq_seen}, 8'h00);
    rc(A_CNT_HI, 8'h00);
    rc(A_STATUS, 8'h85);
    cpu.wr(A_CLKSTOP, 8'hfb);
    rc(A_CLKSTOP, 8'hfb);
    chk({7'h00, o_standby}, 8'h01);
    tk(1'b1);
    rc(A_CNT_HI, 8'h00);
    $display("split test done");
    final_report();
  end
endmodule : dmt_status_cpu_port_bench
